// file: pkg/smim_defines.svh
// register map, field positions, reset values and encodings for the input map block
`ifndef SMIM_DEFINES_SVH
`define SMIM_DEFINES_SVH

// gpio population, padded up to the 32-bit input bus
`define SMIM_GPIO_COUNT        30
`define SMIM_BUS_W             32
`define SMIM_BASE_W            5
`define SMIM_INSTR_W           16

// avalon word indices
`define SMIM_ADDR_W            3
`define SMIM_REG_CTRL          3'h0
`define SMIM_REG_IN_BASE       3'h1
`define SMIM_REG_SYNC_BYPASS   3'h2
`define SMIM_REG_FORCED_INSTR  3'h3
`define SMIM_REG_STATUS        3'h4

// field positions
`define SMIM_CTRL_RESTART_BIT  0
`define SMIM_STAT_STALLED_BIT  0
`define SMIM_STAT_LATCH_BIT    1

// reset values
`define SMIM_BYPASS_RST        32'h0000_0000
`define SMIM_BASE_RST          5'h00
`define SMIM_INSTR_RST         16'h0000
`define SMIM_DATA_RST          32'h0000_0000

// no-operation encoding that releases a stalled forced instruction
`define SMIM_INSTR_NOP         16'hA042

`endif

// file: pkg/smim_pkg.sv
// types shared by the input map and forced execution block
package smim_pkg;

  // where an issued instruction came from
  typedef enum logic [1:0] {
    src_mem,
    src_latch,
    src_force
  } smim_src_t;

  // one instruction handed to the execution core
  typedef struct packed {
    logic        valid;
    smim_src_t   src;
    logic [15:0] instr;
    logic        ignore_delay;
    logic        hold_pc;
  } smim_issue_t;

  // shift-out or move execute request from the core
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } smim_exec_req_t;

  // avalon request bundle
  typedef struct packed {
    logic        read;
    logic        write;
    logic [2:0]  address;
    logic [31:0] writedata;
  } smim_avs_req_t;

endpackage : smim_pkg

// file: core/smim_core.sv
// input mapping, synchronisers and out-of-band instruction issue
//
// Function
// - input bus bit0 is base pin, rotating upward
// - missing upper gpio positions read as zero
// - absolute pin waits use the unrotated gpio bus
// - every input without its bypass bit set passes a two flop synchroniser
// - per pin bypass mask skips the synchroniser
// - latch, shift-out and forced port feed execution
// - forced write executes at once instead of memory
// - forced instruction never advances the program counter
// - forced instruction ignores delay and clock enable
// - stalled forced instruction latched, retried, flagged stalled
// - restart or forced nop clears the stalled flag
// - shift-out execute runs, produced instruction next cycle
// - latch executes next cycle without pc advance
// - at most one shift-out load per cycle
// - stalled forced instruction overwrites the shared latch
// - low sixteen bits of shifted word execute
// - clock enable low idles the machine except forced issue and stalled retry
`timescale 1ns/1ns
`default_nettype none
`include "smim_defines.svh"

module smim_core (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // avalon slave
  input  wire smim_pkg::smim_avs_req_t avs_req,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  // gpio inputs
  input  wire logic [`SMIM_GPIO_COUNT-1:0] gpio_in,
  // execution core side
  input  wire logic                   clk_en,
  input  wire logic [15:0]            mem_instr,
  input  wire logic                   exec_stall,
  input  wire smim_pkg::smim_exec_req_t out_exec,
  input  wire smim_pkg::smim_exec_req_t mov_exec,
  // to execution core
  output smim_pkg::smim_issue_t       issue_ff,
  output logic [31:0]                 in_bus_ff,
  output logic [31:0]                 gpio_abs_ff,
  output logic                        sm_restart_ff,
  output logic                        forced_instr_stalled_flag
);
  import smim_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] smim_rotr(input logic [31:0] v, input logic [4:0] n);
    logic [63:0] d;
    d = {v, v} >> n;
    return d[31:0];
  endfunction : smim_rotr

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave, one wait cycle per access

  logic                      ack_ff;
  logic                      wait_ff;
  logic [31:0]               rdata_ff;
  logic [`SMIM_BASE_W-1:0]   in_base_ff;
  logic [31:0]               bypass_ff;
  logic [`SMIM_INSTR_W-1:0]  last_forced_ff;
  logic                      stalled_ff;
  logic                      latch_vld_ff;
  logic [`SMIM_INSTR_W-1:0]  latch_ff;

  wire        req_any      = avs_req.read | avs_req.write;
  wire        nxt_ack      = req_any & ~ack_ff;
  wire        wr_commit    = avs_req.write & ack_ff;
  wire        wr_ctrl      = wr_commit & (avs_req.address == `SMIM_REG_CTRL);
  wire        wr_base      = wr_commit & (avs_req.address == `SMIM_REG_IN_BASE);
  wire        wr_bypass    = wr_commit & (avs_req.address == `SMIM_REG_SYNC_BYPASS);
  wire        force_wr     = wr_commit & (avs_req.address == `SMIM_REG_FORCED_INSTR);
  wire        wr_restart   = wr_ctrl & avs_req.writedata[`SMIM_CTRL_RESTART_BIT];
  wire [15:0] force_instr  = avs_req.writedata[`SMIM_INSTR_W-1:0];
  wire        nop_wr       = force_wr & (force_instr == `SMIM_INSTR_NOP);

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = `SMIM_DATA_RST;
    case (avs_req.address)
      `SMIM_REG_IN_BASE:      rd_mux[`SMIM_BASE_W-1:0] = in_base_ff;
      `SMIM_REG_SYNC_BYPASS:  rd_mux = bypass_ff;
      `SMIM_REG_FORCED_INSTR: rd_mux[`SMIM_INSTR_W-1:0] = last_forced_ff;
      `SMIM_REG_STATUS:
      begin
        rd_mux[`SMIM_STAT_STALLED_BIT] = stalled_ff;
        rd_mux[`SMIM_STAT_LATCH_BIT]   = latch_vld_ff;
      end
      default:                rd_mux = `SMIM_DATA_RST;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_ff   <= 1'b0;
      wait_ff  <= 1'b1;
      rdata_ff <= `SMIM_DATA_RST;
    end
    else
    begin
      ack_ff  <= nxt_ack;
      wait_ff <= ~nxt_ack;
      if (nxt_ack & avs_req.read)
        rdata_ff <= rd_mux;
    end
  end

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wait_ff;

  // configuration registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_base_ff     <= `SMIM_BASE_RST;
      bypass_ff      <= `SMIM_BYPASS_RST;
      last_forced_ff <= `SMIM_INSTR_RST;
      sm_restart_ff  <= 1'b0;
    end
    else
    begin
      if (wr_base)
        in_base_ff <= avs_req.writedata[`SMIM_BASE_W-1:0];
      if (wr_bypass)
        bypass_ff <= avs_req.writedata;
      if (force_wr)
        last_forced_ff <= force_instr;
      sm_restart_ff <= wr_restart;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input path: synchroniser, bypass, padding, rotation

  logic [`SMIM_GPIO_COUNT-1:0] sync1_ff;
  logic [`SMIM_GPIO_COUNT-1:0] sync2_ff;

  wire [`SMIM_GPIO_COUNT-1:0] byp_sel  = bypass_ff[`SMIM_GPIO_COUNT-1:0];
  wire [`SMIM_GPIO_COUNT-1:0] pin_sel  = (byp_sel & gpio_in) | (~byp_sel & sync2_ff);
  wire [31:0]                 pin_pad  = {{(`SMIM_BUS_W-`SMIM_GPIO_COUNT){1'b0}}, pin_sel};
  wire [31:0]                 pin_rot  = smim_rotr(pin_pad, in_base_ff);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_ff    <= '0;
      sync2_ff    <= '0;
      gpio_abs_ff <= `SMIM_DATA_RST;
      in_bus_ff   <= `SMIM_DATA_RST;
    end
    else
    begin
      sync1_ff    <= gpio_in;
      sync2_ff    <= sync1_ff;
      gpio_abs_ff <= pin_pad;
      in_bus_ff   <= pin_rot;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction latch and issue

  wire cur_force  = issue_ff.valid & (issue_ff.src == src_force);
  wire cur_latch  = issue_ff.valid & (issue_ff.src == src_latch);
  wire fstall     = cur_force & exec_stall;
  wire consumed   = cur_latch & ~exec_stall;
  wire out_load   = issue_ff.valid & out_exec.valid;
  wire mov_load   = issue_ff.valid & mov_exec.valid & ~out_exec.valid;

  logic                     nxt_latch_vld;
  logic [`SMIM_INSTR_W-1:0] nxt_latch;
  logic                     nxt_stalled;
  smim_issue_t              nxt_issue;

  always_comb
  begin
    nxt_latch_vld = latch_vld_ff;
    nxt_latch     = latch_ff;
    if (fstall)
    begin
      nxt_latch_vld = 1'b1;
      nxt_latch     = issue_ff.instr;
    end
    else if (out_load)
    begin
      nxt_latch_vld = 1'b1;
      nxt_latch     = out_exec.data[`SMIM_INSTR_W-1:0];
    end
    else if (mov_load)
    begin
      nxt_latch_vld = 1'b1;
      nxt_latch     = mov_exec.data[`SMIM_INSTR_W-1:0];
    end
    else if (wr_restart | (nop_wr & stalled_ff) | consumed)
      nxt_latch_vld = 1'b0;
  end

  always_comb
  begin
    nxt_stalled = stalled_ff;
    if (fstall)
      nxt_stalled = 1'b1;
    else if (wr_restart | nop_wr | (consumed & stalled_ff))
      nxt_stalled = 1'b0;
  end

  always_comb
  begin
    nxt_issue = '{valid: 1'b0, src: src_mem, instr: `SMIM_INSTR_RST, ignore_delay: 1'b0, hold_pc: 1'b0};
    if (wr_restart)
      nxt_issue.valid = 1'b0;
    else if (force_wr)
    begin
      nxt_issue.valid        = 1'b1;
      nxt_issue.src          = src_force;
      nxt_issue.instr        = force_instr;
      nxt_issue.ignore_delay = 1'b1;
      nxt_issue.hold_pc      = 1'b1;
    end
    else if (nxt_latch_vld & (clk_en | nxt_stalled))
    begin
      nxt_issue.valid        = 1'b1;
      nxt_issue.src          = src_latch;
      nxt_issue.instr        = nxt_latch;
      nxt_issue.ignore_delay = nxt_stalled;
      nxt_issue.hold_pc      = 1'b1;
    end
    else if (clk_en)
    begin
      nxt_issue.valid = 1'b1;
      nxt_issue.instr = mem_instr;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      latch_vld_ff              <= 1'b0;
      latch_ff                  <= `SMIM_INSTR_RST;
      stalled_ff                <= 1'b0;
      forced_instr_stalled_flag <= 1'b0;
      issue_ff                  <= '{valid: 1'b0, src: src_mem, instr: `SMIM_INSTR_RST,
                                     ignore_delay: 1'b0, hold_pc: 1'b0};
    end
    else
    begin
      latch_vld_ff              <= nxt_latch_vld;
      latch_ff                  <= nxt_latch;
      stalled_ff                <= nxt_stalled;
      forced_instr_stalled_flag <= nxt_stalled;
      issue_ff                  <= nxt_issue;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_shift_load;
    out_load && !fstall;
  endsequence

  sequence s_next_run;
    clk_en && !force_wr && !wr_restart;
  endsequence

  sequence s_move_load;
    mov_load && !fstall;
  endsequence

  in_rotate_a: assert property (in_bus_ff == smim_rotr(gpio_abs_ff, $past(in_base_ff)))
    else $error("input bus is not the rotated gpio bus");

  pad_zero_a: assert property (gpio_abs_ff[31:`SMIM_GPIO_COUNT] == '0)
    else $error("absent gpio positions not zero");

  sync_delay_a: assert property ((gpio_abs_ff[`SMIM_GPIO_COUNT-1:0] & ~$past(byp_sel))
    == ($past(gpio_in, 3) & ~$past(byp_sel)))
    else $error("synchronised pin latency wrong");

  bypass_path_a: assert property ((gpio_abs_ff[`SMIM_GPIO_COUNT-1:0] & $past(byp_sel))
    == ($past(gpio_in) & $past(byp_sel)))
    else $error("bypassed pin latency wrong");

  forced_issue_a: assert property (force_wr && !wr_restart |=> issue_ff.valid && issue_ff.hold_pc
    && issue_ff.ignore_delay && issue_ff.instr == $past(force_instr))
    else $error("forced write not issued at once");

  idle_off_a: assert property (!clk_en && !force_wr && !nxt_stalled |=> !issue_ff.valid)
    else $error("issue while clock enable low");

  shift_exec_a: assert property (s_shift_load ##0 s_next_run |=> issue_ff.valid
    && issue_ff.src == src_latch && issue_ff.hold_pc && issue_ff.instr == $past(out_exec.data[15:0]))
    else $error("shifted instruction not run next cycle");

  stall_flag_a: assert property (fstall |=> forced_instr_stalled_flag && latch_vld_ff
    && latch_ff == $past(issue_ff.instr))
    else $error("stalled forced instruction not latched");

  nop_clear_a: assert property ((nop_wr || wr_restart) && !fstall |=> !forced_instr_stalled_flag)
    else $error("stalled flag not cleared");

  // issue source, latch and retry checks
  move_exec_a: assert property (s_move_load ##0 s_next_run |=> issue_ff.valid
    && issue_ff.src == src_latch && issue_ff.instr == $past(mov_exec.data[15:0]))
    else $error("moved instruction not run next cycle");

  one_shift_a: assert property (s_shift_load ##0 mov_exec.valid
    |=> latch_vld_ff && latch_ff == $past(out_exec.data[15:0]))
    else $error("second exec source loaded in the same cycle");

  latch_clear_a: assert property (consumed && !out_load && !mov_load |=> !latch_vld_ff)
    else $error("latched instruction not retired");

  restart_quiet_a: assert property (wr_restart |=> !issue_ff.valid && sm_restart_ff)
    else $error("restart did not suppress issue");

  stall_retry_a: assert property (forced_instr_stalled_flag && exec_stall && !force_wr && !wr_restart
    |=> issue_ff.valid && issue_ff.src == src_latch && issue_ff.ignore_delay && forced_instr_stalled_flag)
    else $error("stalled forced instruction not retried");

  mem_issue_a: assert property (clk_en && !force_wr && !wr_restart && !nxt_latch_vld |=> issue_ff.valid
    && issue_ff.src == src_mem && !issue_ff.hold_pc && issue_ff.instr == $past(mem_instr))
    else $error("memory instruction not issued on enable");

endmodule : smim_core

`default_nettype wire

// file: tb/smim_core_tb.sv
// self-checking bench for the input map and forced execution block
`timescale 1ns/1ns
`default_nettype none
`include "smim_defines.svh"

module smim_core_tb;
  import smim_pkg::*;

  logic                        clk_sys;
  logic                        rst_n;
  smim_avs_req_t               avs_req;
  logic [31:0]                 avs_readdata;
  logic                        avs_waitrequest;
  logic [`SMIM_GPIO_COUNT-1:0] gpio_in;
  logic                        clk_en;
  logic [15:0]                 mem_instr;
  logic                        exec_stall;
  smim_exec_req_t              out_exec;
  smim_exec_req_t              mov_exec;
  smim_issue_t                 issue_ff;
  logic [31:0]                 in_bus_ff;
  logic [31:0]                 gpio_abs_ff;
  logic                        sm_restart_ff;
  logic                        forced_instr_stalled_flag;
  logic [31:0]                 rd;
  int                          n_fail;
  int                          checks_done;

  smim_core dut (
    .clk_sys                   (clk_sys),
    .rst_n                     (rst_n),
    .avs_req                   (avs_req),
    .avs_readdata              (avs_readdata),
    .avs_waitrequest           (avs_waitrequest),
    .gpio_in                   (gpio_in),
    .clk_en                    (clk_en),
    .mem_instr                 (mem_instr),
    .exec_stall                (exec_stall),
    .out_exec                  (out_exec),
    .mov_exec                  (mov_exec),
    .issue_ff                  (issue_ff),
    .in_bus_ff                 (in_bus_ff),
    .gpio_abs_ff               (gpio_abs_ff),
    .sm_restart_ff             (sm_restart_ff),
    .forced_instr_stalled_flag (forced_instr_stalled_flag)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checks_done++;
      if (got !== exp)
      begin
        n_fail++;
        $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask : chk

  task automatic tick(input int n);
    begin
      repeat (n) @(posedge clk_sys);
    end
  endtask : tick

  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [2:0] adr, input logic [31:0] wd);
    int n;
    begin
      @(posedge clk_sys);
      avs_req <= '{read: !wr, write: wr, address: adr, writedata: wd};
      n = 0;
      do
      begin
        @(posedge clk_sys);
        n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 40);
      rd = avs_readdata;
      avs_req <= '0;
      if (n >= 40)
      begin
        n_fail++;
        finish_test();
      end
    end
  endtask : bus

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_latency;
    begin
      bus(1'b0, `SMIM_REG_SYNC_BYPASS, 32'h0);
      chk(rd, `SMIM_BYPASS_RST);
      tick(2);
      gpio_in[3] <= 1'b1;
      tick(3);
      chk(32'(gpio_abs_ff[3]), 32'h0);
      tick(1);
      chk(32'(gpio_abs_ff[3]), 32'h1);
      bus(1'b1, `SMIM_REG_SYNC_BYPASS, 32'h0000_0008);
      tick(1);
      gpio_in[4:3] <= 2'b10;
      tick(2);
      chk(32'(gpio_abs_ff[4:3]), 32'h0);
      tick(2);
      chk(32'(gpio_abs_ff[4:3]), 32'h2);
    end
  endtask : t_latency

  task automatic t_map;
    int          bl[4] = '{0, 1, 29, 31};
    logic [31:0] a;
    begin
      bus(1'b1, `SMIM_REG_SYNC_BYPASS, 32'hFFFF_FFFF);
      gpio_in <= 30'h2000_0006;
      for (int i = 0; i < 4; i++)
      begin
        bus(1'b1, `SMIM_REG_IN_BASE, 32'(bl[i]));
        tick(3);
        a = 32'(gpio_in);
        chk(gpio_abs_ff, a);
        chk(in_bus_ff, (a >> bl[i]) | (a << (32 - bl[i])));
        bus(1'b0, `SMIM_REG_IN_BASE, 32'h0);
        chk(rd, 32'(bl[i]));
      end
    end
  endtask : t_map

  task automatic t_forced;
    begin
      bus(1'b1, `SMIM_REG_FORCED_INSTR, 32'h0000_E7C5);
      tick(1);
      chk(32'({issue_ff.valid, issue_ff.src, issue_ff.instr}), 32'({1'b1, src_force, 16'hE7C5}));
      chk(32'({issue_ff.ignore_delay, issue_ff.hold_pc}), 32'h3);
      tick(1);
      chk(32'(issue_ff.valid), 32'h0);
    end
  endtask : t_forced

  // stall a forced instruction, then release it by nop or restart
  task automatic t_stall(input logic rs);
    int n;
    begin
      bus(1'b1, `SMIM_REG_FORCED_INSTR, 32'h0000_2081);
      exec_stall <= 1'b1;
      tick(2);
      chk(32'(forced_instr_stalled_flag), 32'h1);
      chk(32'({issue_ff.src, issue_ff.instr, issue_ff.ignore_delay}), 32'({src_latch, 16'h2081, 1'b1}));
      bus(1'b0, `SMIM_REG_STATUS, 32'h0);
      chk(rd, (32'h1 << `SMIM_STAT_STALLED_BIT) | (32'h1 << `SMIM_STAT_LATCH_BIT));
      bus(1'b0, `SMIM_REG_FORCED_INSTR, 32'h0);
      chk(rd, 32'h0000_2081);
      if (rs)
        bus(1'b1, `SMIM_REG_CTRL, 32'h1);
      else
        bus(1'b1, `SMIM_REG_FORCED_INSTR, 32'(`SMIM_INSTR_NOP));
      exec_stall <= 1'b0;
      n = 0;
      repeat (3)
      begin
        @(posedge clk_sys);
        if (sm_restart_ff === 1'b1)
          n++;
      end
      chk(32'(n), 32'(rs));
      chk(32'({forced_instr_stalled_flag, issue_ff.valid}), 32'h0);
      bus(1'b0, `SMIM_REG_STATUS, 32'h0);
      chk(rd, 32'h0);
    end
  endtask : t_stall

  // stalled forced instruction retried from the latch until it completes
  task automatic t_retry;
    begin
      bus(1'b1, `SMIM_REG_FORCED_INSTR, 32'h0000_2081);
      exec_stall <= 1'b1;
      tick(3);
      exec_stall <= 1'b0;
      tick(1);
      chk(32'({forced_instr_stalled_flag, issue_ff.valid, issue_ff.src}), 32'({1'b1, 1'b1, src_latch}));
      tick(1);
      chk(32'({forced_instr_stalled_flag, issue_ff.valid}), 32'h0);
    end
  endtask : t_retry

  task automatic t_exec(input logic ov, input logic mv);
    begin
      mem_instr <= 16'h0123;
      clk_en <= 1'b1;
      tick(1);
      out_exec <= '{valid: ov, data: 32'h5A5A_6047};
      mov_exec <= '{valid: mv, data: 32'hA5A5_4321};
      tick(1);
      out_exec <= '0;
      mov_exec <= '0;
      chk(32'({issue_ff.valid, issue_ff.src}), 32'({1'b1, src_mem}));
      tick(1);
      chk(32'({issue_ff.src, issue_ff.instr, issue_ff.hold_pc}), 32'({src_latch, ov ? 16'h6047 : 16'h4321, 1'b1}));
      tick(1);
      chk(32'({issue_ff.src, issue_ff.instr}), 32'({src_mem, 16'h0123}));
      clk_en <= 1'b0;
      tick(2);
    end
  endtask : t_exec

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    n_fail = 0;
    checks_done = 0;
    rst_n = 1'b0;
    avs_req = '0;
    gpio_in = '0;
    clk_en = 1'b0;
    mem_instr = '0;
    exec_stall = 1'b0;
    out_exec = '0;
    mov_exec = '0;
    tick(20);
    chk(32'(avs_waitrequest), 32'h1);
    chk(32'({issue_ff.valid, sm_restart_ff, forced_instr_stalled_flag}), 32'h0);
    rst_n <= 1'b1;
    t_latency();
    t_map();
    t_forced();
    t_stall(1'b0);
    t_stall(1'b1);
    t_retry();
    t_exec(1'b1, 1'b0);
    t_exec(1'b0, 1'b1);
    t_exec(1'b1, 1'b1);
    finish_test();
  end

endmodule : smim_core_tb

`default_nettype wire
